/* File: hw/vipc_pkg.sv */
// Package of constants and types for the video input pin control block
// Summary of operation
// - Sample the 24-bit pixel bus each CLOCK rise
// - Sync direction low: syncs are inputs, time data
// - Sync direction high: drive vertical sync out
// - Sync direction high, CPU mode low: drive horizontal sync out
// - CPU mode: horizontal sync pin is write strobe
// - Data valid high marks active picture, else blanking
// - CPU mode: data valid pin is chip select
// - Address select low gives 76h, high 75h
// - 7-bit address 11101, inverse select, select
// - Held in reset while hard reset pin low
// - Scan enable high sets scan test precondition
// - Serial data open drain, never driven high
package vipc_pkg;
    localparam int        PIXEL_W         = 24;
    localparam logic [4:0] ADDR_FIXED     = 5'h1d;
    localparam logic [6:0] ADDR_SEL_LOW   = 7'h76;
    localparam logic [6:0] ADDR_SEL_HIGH  = 7'h75;
    localparam int        SYNC_STAGES     = 2;
    localparam logic [PIXEL_W-1:0] PIXEL_RESET = 24'h000000;

    typedef struct packed {
        logic               active;
        logic               hsync;
        logic               vsync;
        logic [PIXEL_W-1:0] data;
    } vipc_pixel_t;

    typedef struct packed {
        logic write_n;
        logic select_n;
    } vipc_host_t;
endpackage : vipc_pkg

/* File: hw/vipc_sync2.sv */
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
`default_nettype none
module vipc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             CLOCK,
    input  wire logic             RST,
    input  wire logic [WIDTH-1:0] D,
    output logic      [WIDTH-1:0] Q
);
    import vipc_pkg::*;
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    initial if (WIDTH < 1) $error("width must be positive");

    // First stage is read only by the second
    always_comb
    begin
        meta_next = D;
        q_next    = meta_reg;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            meta_reg <= '0;
            Q        <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            Q        <= q_next;
        end
    end
endmodule // vipc_sync2
`default_nettype wire

/* File: hw/vipc_top.sv */
// Pin-level control of the digital video input side
`timescale 1ns/100ps
`default_nettype none
module vipc_top #(
    parameter int PIXEL_WIDTH = vipc_pkg::PIXEL_W
) (
    input  wire logic                         CLOCK,
    input  wire logic                         RST,
    input  wire logic [PIXEL_WIDTH-1:0]       PIXEL_DATA,
    input  wire logic                         VSYNC_IN,
    output logic                              VSYNC_OUT,
    output logic                              VSYNC_OE,
    input  wire logic                         HSYNC_OR_WRITE_STROBE_IN,
    output logic                              HSYNC_OR_WRITE_STROBE_OUT,
    output logic                              HSYNC_OR_WRITE_STROBE_OE,
    input  wire logic                         DATA_VALID_OR_CHIP_SELECT,
    input  wire logic                         SYNC_DIRECTION_SELECT,
    input  wire logic                         CPU_MODE,
    input  wire logic                         GEN_VSYNC,
    input  wire logic                         GEN_HSYNC,
    input  wire logic                         SLAVE_ADDR_SELECT,
    input  wire logic                         HARD_RESET_N,
    input  wire logic                         SERIAL_RESET_REQ,
    input  wire logic                         SCAN_TEST_ENABLE,
    input  wire logic                         SERIAL_DATA_LINE_IN,
    input  wire logic                         SERIAL_DATA_PULL_LOW,
    output logic                              SERIAL_DATA_LINE_OUT,
    output logic                              SERIAL_DATA_LINE_OE,
    input  wire logic                         SERIAL_CLOCK_LINE,
    output vipc_pkg::vipc_pixel_t             PIXEL_OUT,
    output logic                              PIXEL_WRITE,
    output vipc_pkg::vipc_host_t              HOST_STROBES,
    output logic [6:0]                        SLAVE_ADDR,
    output logic                              CORE_RESET,
    output logic                              SCAN_MODE,
    output logic                              SERIAL_DATA_SAMPLED,
    output logic                              SERIAL_CLOCK_SAMPLED
);
    import vipc_pkg::*;

    localparam int NS = PIXEL_WIDTH + 9;

    logic [NS-1:0]          pin_raw;
    logic [NS-1:0]          pin_sync;
    logic [PIXEL_WIDTH-1:0] pix_s;
    logic                   vs_s;
    logic                   hs_s;
    logic                   de_s;
    logic                   as_s;
    logic                   rstn_s;
    logic                   scan_s;
    logic                   sda_s;
    logic                   scl_s;
    logic                   reset_s;
    vipc_pixel_t            pixel_reg;
    vipc_pixel_t            pixel_next;
    logic                   write_reg;
    logic                   write_next;
    vipc_host_t             host_reg;
    vipc_host_t             host_next;
    logic [6:0]             addr_reg;
    logic [6:0]             addr_next;
    logic                   core_rst_reg;
    logic                   core_rst_next;
    logic                   scan_reg;
    logic                   scan_next;
    logic                   vs_out_reg;
    logic                   vs_out_next;
    logic                   hs_out_reg;
    logic                   hs_out_next;

    initial if (PIXEL_WIDTH != PIXEL_W) $error("pixel bus must be 24 bits");

    // Every pin but the mode, direction, generator and pull controls crosses two flops before use; serial clock is sampled too
    assign pin_raw = {PIXEL_DATA, VSYNC_IN, HSYNC_OR_WRITE_STROBE_IN,
                      DATA_VALID_OR_CHIP_SELECT, SLAVE_ADDR_SELECT, HARD_RESET_N,
                      SCAN_TEST_ENABLE, SERIAL_DATA_LINE_IN, SERIAL_CLOCK_LINE,
                      SERIAL_RESET_REQ};

    vipc_sync2 #(
        .WIDTH (NS)
    ) u_sync (
        .CLOCK (CLOCK),
        .RST   (RST),
        .D     (pin_raw),
        .Q     (pin_sync)
    );

    assign {pix_s, vs_s, hs_s, de_s, as_s, rstn_s, scan_s, sda_s, scl_s, reset_s} = pin_sync;

    // Pixel capture; blanking samples never reach the picture path
    always_comb
    begin
        pixel_next = pixel_reg;
        write_next = 1'b0;
        host_next  = host_reg;
        if (CPU_MODE)
        begin
            host_next.write_n  = hs_s;
            host_next.select_n = de_s;
            pixel_next.active  = 1'b0;
        end
        else
        begin
            host_next  = '{write_n: 1'b1, select_n: 1'b1};
            pixel_next.hsync  = SYNC_DIRECTION_SELECT ? hs_out_reg : hs_s;
            pixel_next.vsync  = SYNC_DIRECTION_SELECT ? vs_out_reg : vs_s;
            pixel_next.active = de_s;
            if (de_s)
            begin
                pixel_next.data = pix_s;
                write_next      = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            pixel_reg <= '{active: 1'b0, hsync: 1'b0, vsync: 1'b0, data: PIXEL_RESET};
            write_reg <= 1'b0;
            host_reg  <= '{write_n: 1'b1, select_n: 1'b1};
        end
        else
        begin
            pixel_reg <= pixel_next;
            write_reg <= write_next;
            host_reg  <= host_next;
        end
    end

    // Sync drive; direction bit is a same-domain control, so no sync stage
    always_comb
    begin
        vs_out_next = GEN_VSYNC;
        hs_out_next = GEN_HSYNC;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            vs_out_reg <= 1'b0;
            hs_out_reg <= 1'b0;
        end
        else
        begin
            vs_out_reg <= vs_out_next;
            hs_out_reg <= hs_out_next;
        end
    end

    // Pin stays undriven in CPU mode so the host owns the strobe
    assign VSYNC_OUT                 = vs_out_reg;
    assign VSYNC_OE                  = SYNC_DIRECTION_SELECT;
    assign HSYNC_OR_WRITE_STROBE_OUT = hs_out_reg;
    assign HSYNC_OR_WRITE_STROBE_OE  = SYNC_DIRECTION_SELECT & ~CPU_MODE;

    // Address, reset and scan controls
    always_comb
    begin
        addr_next     = {ADDR_FIXED, ~as_s, as_s};
        core_rst_next = rstn_s ? reset_s : 1'b1;
        scan_next     = scan_s;
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            addr_reg     <= ADDR_SEL_LOW;
            core_rst_reg <= 1'b1;
            scan_reg     <= 1'b0;
        end
        else
        begin
            addr_reg     <= addr_next;
            core_rst_reg <= core_rst_next;
            scan_reg     <= scan_next;
        end
    end

    // Open drain: output is always low, only the enable moves
    assign SERIAL_DATA_LINE_OUT = 1'b0;
    assign SERIAL_DATA_LINE_OE  = SERIAL_DATA_PULL_LOW & ~RST;

    assign PIXEL_OUT            = pixel_reg;
    assign PIXEL_WRITE          = write_reg;
    assign HOST_STROBES         = host_reg;
    assign SLAVE_ADDR           = addr_reg;
    assign CORE_RESET           = core_rst_reg;
    assign SCAN_MODE            = scan_reg;
    assign SERIAL_DATA_SAMPLED  = sda_s;
    assign SERIAL_CLOCK_SAMPLED = scl_s;

    AST_WRITE_ONLY_ACTIVE: assert property (@(posedge CLOCK) disable iff (RST)
        PIXEL_WRITE |-> PIXEL_OUT.active)
        else $error("pixel written during blanking");
    AST_DATA_CAPTURE: assert property (@(posedge CLOCK) disable iff (RST)
        (de_s && !CPU_MODE) |=> (PIXEL_OUT.data == $past(pix_s) && PIXEL_WRITE))
        else $error("active pixel not captured");
    AST_BLANK_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        (!de_s) |=> (!PIXEL_OUT.active && $stable(PIXEL_OUT.data)))
        else $error("blanking changed picture");
    AST_SYNC_IN: assert property (@(posedge CLOCK) disable iff (RST)
        (!SYNC_DIRECTION_SELECT && !CPU_MODE) |-> (!VSYNC_OE && !HSYNC_OR_WRITE_STROBE_OE)
        ##1 (PIXEL_OUT.hsync == $past(hs_s)))
        else $error("sync input not used");
    AST_VSYNC_OUT: assert property (@(posedge CLOCK) disable iff (RST)
        SYNC_DIRECTION_SELECT |-> (VSYNC_OE && VSYNC_OUT == $past(GEN_VSYNC)))
        else $error("vertical sync not driven");
    AST_HSYNC_OUT: assert property (@(posedge CLOCK) disable iff (RST)
        (SYNC_DIRECTION_SELECT && !CPU_MODE) |-> (HSYNC_OR_WRITE_STROBE_OE
        && HSYNC_OR_WRITE_STROBE_OUT == $past(GEN_HSYNC)))
        else $error("horizontal sync not driven");
    AST_HOST_STROBES: assert property (@(posedge CLOCK) disable iff (RST)
        CPU_MODE |=> (HOST_STROBES.write_n == $past(hs_s)
        && HOST_STROBES.select_n == $past(de_s) && !PIXEL_WRITE))
        else $error("host strobes wrong");
    AST_ADDR: assert property (@(posedge CLOCK) disable iff (RST)
        1'b1 |=> (SLAVE_ADDR == ($past(as_s) ? ADDR_SEL_HIGH : ADDR_SEL_LOW)))
        else $error("slave address wrong");
    AST_RESET_HELD: assert property (@(posedge CLOCK) disable iff (RST)
        !rstn_s |=> CORE_RESET)
        else $error("reset released while pin low");
    AST_SERIAL_RESET: assert property (@(posedge CLOCK) disable iff (RST)
        rstn_s |=> (CORE_RESET == $past(reset_s)))
        else $error("serial reset not followed");
    AST_SCAN: assert property (@(posedge CLOCK) disable iff (RST)
        1'b1 |=> (SCAN_MODE == $past(scan_s)))
        else $error("scan mode wrong");
    AST_OPEN_DRAIN: assert property (@(posedge CLOCK) disable iff (RST)
        !SERIAL_DATA_LINE_OUT && (SERIAL_DATA_LINE_OE == SERIAL_DATA_PULL_LOW))
        else $error("serial data driven high");
endmodule // vipc_top
`default_nettype wire

/* File: dv/vipc_gfx_model.sv */
// Graphics controller model driving the pixel bus, data valid and syncs
`timescale 1ns/100ps
`default_nettype none
module vipc_gfx_model (
    input  wire logic        CLOCK,
    input  wire logic        en,
    input  wire logic [26:0] req,
    output logic [23:0]      pix = 24'h000000,
    output logic             de = 1'b0,
    output logic             hs = 1'b0,
    output logic             vs = 1'b0
);
    logic pclk = 1'b0;
    logic pclk_d = 1'b0;

    // Pixel clock runs only inside frames and stands still between them
    always #80 if (en) pclk = ~pclk;

    // Pins move once per pixel clock rise; released bus never keeps stale data
    always @(negedge CLOCK)
    begin
        pclk_d <= pclk;
        if (pclk && !pclk_d)
            {vs, de, hs, pix} <= req;
        else if (!en)
            pix <= ~pix;
    end
endmodule // vipc_gfx_model
`default_nettype wire

/* File: dv/tb_vipc_top.sv */
// Self-checking bench for the video input pin control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) check(32'(a), 32'(e))
module tb_vipc_top;
    import vipc_pkg::*;
    typedef struct {
        logic [26:0] req;
        logic        cpu;
        logic [26:0] exp;
    } vipc_row_t;

    logic CLOCK = 1'b0, RST = 1'b1, en = 1'b0, cpu = 1'b0, dir = 1'b0;
    logic gv = 1'b0, gh = 1'b0, as = 1'b0, hrn = 1'b1, srq = 1'b0;
    logic scan = 1'b0, pull = 1'b0, scl = 1'b1;
    logic [26:0] req = 27'h0000000;
    logic [23:0] pix;
    logic de, hs, vs, vo, voe, ho, hoe, sdo, sdoe, wr, cr, sm, sds, scs;
    vipc_pixel_t po;
    vipc_host_t hst;
    logic [6:0] sa;
    int miscompares = 0, n_compared = 0, cyc = 0;

    // Inputs {vs, de, hs, pix}; outputs {write, strobes, data}
    vipc_row_t rows[6] = '{
        '{27'h2a5c3e1, 1'b0, 27'h7a5c3e1},
        '{27'h75a3c1e, 1'b0, 27'h75a3c1e},
        '{27'h0ffffff, 1'b0, 27'h35a3c1e},
        '{27'h0123456, 1'b1, 27'h05a3c1e},
        '{27'h2123456, 1'b1, 27'h15a3c1e},
        '{27'h1123456, 1'b1, 27'h25a3c1e}
    };

    vipc_gfx_model gfx (.CLOCK(CLOCK), .en(en), .req(req), .pix(pix),
        .de(de), .hs(hs), .vs(vs));

    // Shared pins resolve to whoever drives them; serial data has a pull-up
    vipc_top dut (.CLOCK(CLOCK), .RST(RST), .PIXEL_DATA(pix),
        .VSYNC_IN(voe ? vo : vs), .VSYNC_OUT(vo), .VSYNC_OE(voe),
        .HSYNC_OR_WRITE_STROBE_IN(hoe ? ho : hs),
        .HSYNC_OR_WRITE_STROBE_OUT(ho), .HSYNC_OR_WRITE_STROBE_OE(hoe),
        .DATA_VALID_OR_CHIP_SELECT(de), .SYNC_DIRECTION_SELECT(dir),
        .CPU_MODE(cpu), .GEN_VSYNC(gv), .GEN_HSYNC(gh),
        .SLAVE_ADDR_SELECT(as), .HARD_RESET_N(hrn), .SERIAL_RESET_REQ(srq),
        .SCAN_TEST_ENABLE(scan), .SERIAL_DATA_LINE_IN(~(sdoe & ~sdo)),
        .SERIAL_DATA_PULL_LOW(pull), .SERIAL_DATA_LINE_OUT(sdo),
        .SERIAL_DATA_LINE_OE(sdoe), .SERIAL_CLOCK_LINE(scl), .PIXEL_OUT(po),
        .PIXEL_WRITE(wr), .HOST_STROBES(hst), .SLAVE_ADDR(sa),
        .CORE_RESET(cr), .SCAN_MODE(sm), .SERIAL_DATA_SAMPLED(sds),
        .SERIAL_CLOCK_SAMPLED(scs));

    // Clock at 125 MHz
    always #4 CLOCK = ~CLOCK;

    task automatic check(input logic [31:0] a, input logic [31:0] e);
        n_compared++;
        if (a !== e)
        begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge CLOCK);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cut a hang short well past the expected run length
    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // Main sequence; inputs move on the falling edge
    initial
    begin
        wt(10);
        `CHK({cr, wr, hst, sm}, 5'h16);
        `CHK(sa, 7'h76);
        RST = 1'b0;
        en = 1'b1;
        $display("reset test done");
        // Rows wait a full pixel clock plus the three-edge pin latency
        foreach (rows[i])
        begin
            cpu = rows[i].cpu;
            req = rows[i].req;
            wt(30);
            `CHK({wr, hst, po.data}, rows[i].exp);
            `CHK({voe, hoe}, 2'h0);
            `CHK({po.active, po.vsync, po.hsync}, rows[i].cpu ? 3'h0 : {rows[i].req[25], rows[i].req[26], rows[i].req[24]});
        end
        $display("row test done");
        en = 1'b0;
        cpu = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            as = k[0];
            scan = (k == 0);
            pull = (k == 0);
            scl = (k != 0);
            wt(4);
            `CHK(sa, {5'h1d, ~as, as});
            `CHK(sm, scan);
            `CHK({sdoe, sdo, sds, scs}, k ? 4'h3 : 4'h8);
        end
        for (int k = 0; k < 4; k++)
        begin
            {hrn, srq} = k[1:0];
            wt(4);
            `CHK(cr, !hrn || srq);
        end
        $display("pin test done");
        dir = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            {gv, gh} = k ? 2'h2 : 2'h1;
            wt(4);
            `CHK({voe, hoe, vo, ho}, {2'h3, gv, gh});
        end
        cpu = 1'b1;
        wt(2);
        `CHK({voe, hoe}, 2'h2);
        $display("sync out test done");
        end_of_test();
    end
endmodule // tb_vipc_top
`default_nettype wire
